/* File: rtl/lsd_core.sv */
// lsd_core: serial shift chain, on-off latch and blanking of 24 sinks
// assumes: pins asynchronous, mclk at least several times the shift clock
module lsd_core #(
	parameter int SHIFT_LEN = lsd_pkg::SHIFT_LEN
) (
	input  wire logic       mclk,         // system clock, 25 MHz
	input  wire logic       rst_n,        // async reset, active low
	input  wire logic       ce,           // clock enable, freezes state low
	input  wire logic       serial_in,    // serial data pin
	input  wire logic       shift_clk,    // shift clock pin
	input  wire logic       load_strobe,  // latch strobe pin
	input  wire logic       force_off,    // blank all sinks pin
	output logic            serial_out,   // chain output, top bit
	output logic      [7:0] red_sinks,    // red group, 1 = on
	output logic      [7:0] green_sinks,  // green group, 1 = on
	output logic      [7:0] blue_sinks    // blue group, 1 = on
);
	// ------------------------------------------------------------
	// pin synchronisation
	// ------------------------------------------------------------
	lsd_pkg::lsd_pins_s pins_raw;
	lsd_pkg::lsd_pins_s pins;
	lsd_pkg::lsd_pins_s pins_prev;
	lsd_pkg::lsd_pins_s next_pins_prev;

	assign pins_raw = '{serial_in: serial_in, shift_clk: shift_clk,
		load_strobe: load_strobe, force_off: force_off};

	// all four pins share one synchroniser so a data bit and its
	// clock edge leave it in the same cycle; mclk must run several
	// times faster than the shift clock or edges are lost
	lsd_sync #(
		.WIDTH ($bits(lsd_pkg::lsd_pins_s))
	) u_sync (
		.mclk  (mclk),
		.rst_n (rst_n),
		.ce    (ce),
		.d     (pins_raw),
		.q     (pins)
	);

	// ------------------------------------------------------------
	// edge detection
	// ------------------------------------------------------------
	logic shift_rise;
	logic strobe_rise;

	// data rides in the same sync stage, so it is sampled as the edge seen
	assign shift_rise  = pins.shift_clk & ~pins_prev.shift_clk;
	assign strobe_rise = pins.load_strobe & ~pins_prev.load_strobe;

	always_comb begin
		next_pins_prev = ce ? pins : pins_prev;
	end

	// ------------------------------------------------------------
	// shift register and latch
	// ------------------------------------------------------------
	logic [SHIFT_LEN-1:0] shreg;
	logic [SHIFT_LEN-1:0] next_shreg;
	logic [23:0]          latch;
	logic [23:0]          next_latch;
	lsd_pkg::lsd_sinks_s  sinks;
	lsd_pkg::lsd_sinks_s  next_sinks;
	logic                 next_serial_out;

	always_comb begin
		next_shreg = shreg;
		next_latch = latch;
		if (ce && shift_rise) begin
			next_shreg = {shreg[SHIFT_LEN-2:0], pins.serial_in};
		end
		// a coincident shift rise leaves the latch with the
		// pre-shift word, since the latch reads the current register
		if (ce && strobe_rise) begin
			next_latch = shreg[23:0];
		end
		next_serial_out = next_shreg[SHIFT_LEN-1];
		next_sinks = pins.force_off ? '0 : lsd_pkg::lsd_sinks_s'(next_latch);
		// ce low holds the outputs too, so a frozen block shows no
		// half-updated sink pattern
		if (!ce) begin
			next_sinks      = sinks;
			next_serial_out = serial_out;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pins_prev  <= '0;
			shreg      <= lsd_pkg::SHIFT_RST;
			latch      <= lsd_pkg::LATCH_RST;
			sinks      <= '0;
			serial_out <= 1'b0;
		end else begin
			pins_prev  <= next_pins_prev;
			shreg      <= next_shreg;
			latch      <= next_latch;
			sinks      <= next_sinks;
			serial_out <= next_serial_out;
		end
	end

	// outputs come straight from the sinks flop; no gating after it
	// so the sink pins cannot glitch when force-off changes
	assign red_sinks   = sinks.red;
	assign green_sinks = sinks.green;
	assign blue_sinks  = sinks.blue;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_blank_forces_off: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(ce && pins.force_off) |=> (sinks == '0))
		else $error("sinks on while forced off");

	chk_sinks_follow_latch: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(ce && !pins.force_off) |=> (sinks == latch))
		else $error("sinks differ from latch");

	chk_strobe_loads: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(ce && strobe_rise) |=> (latch == $past(shreg[23:0])))
		else $error("latch not loaded on strobe");

	chk_latch_holds: assert property (
		@(posedge mclk) disable iff (!rst_n)
		!(ce && strobe_rise) |=> $stable(latch))
		else $error("latch changed without strobe");

	chk_shift_capture: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(ce && shift_rise) |=> (shreg[0] == $past(pins.serial_in)))
		else $error("serial input not captured");

	chk_shift_moves: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(ce && shift_rise) |=>
			(shreg[SHIFT_LEN-1:1] == $past(shreg[SHIFT_LEN-2:0])))
		else $error("bits did not move up");

	chk_shift_idle: assert property (
		@(posedge mclk) disable iff (!rst_n)
		!(ce && shift_rise) |=> $stable(shreg))
		else $error("register moved without edge");

	chk_serial_out_top: assert property (
		@(posedge mclk) disable iff (!rst_n)
		ce |=> (serial_out == shreg[SHIFT_LEN-1]))
		else $error("serial out not top bit");

	chk_out_holds: assert property (
		@(posedge mclk) disable iff (!rst_n)
		!(ce && shift_rise) |=> $stable(serial_out))
		else $error("serial out moved without edge");

	chk_fall_ignored: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(ce && pins_prev.load_strobe && !pins.load_strobe)
			|=> $stable(latch))
		else $error("latch moved on strobe fall");

	chk_red_map: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(ce && !pins.force_off) |=> (red_sinks == latch[7:0]))
		else $error("red sinks not latch bits 7:0");

	chk_green_map: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(ce && !pins.force_off) |=> (green_sinks == latch[15:8]))
		else $error("green sinks not latch bits 15:8");

	chk_blue_map: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(ce && !pins.force_off) |=> (blue_sinks == latch[23:16]))
		else $error("blue sinks not latch bits 23:16");

	chk_freeze_all: assert property (
		@(posedge mclk) disable iff (!rst_n)
		!ce |=> ($stable(shreg) && $stable(latch)
			&& $stable(sinks) && $stable(serial_out)))
		else $error("state moved while ce low");

	// ------------------------------------------------------------
	// pin to state checks, through the synchroniser
	// ------------------------------------------------------------
	// pins take three mclk edges to act: two sync stages and the
	// register stage; ce must stay high over all of them or the
	// frozen stages stretch the delay

	chk_pin_to_lsb: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(ce && $past(ce) && $rose(shift_clk)) ##1 ce ##1 ce
			|=> (shreg[0] == $past(serial_in, 3)))
		else $error("pin data not in register lsb");

	chk_pin_to_latch: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(ce && $past(ce) && $rose(load_strobe)) ##1 ce ##1 ce
			|=> (latch == $past(shreg[23:0])))
		else $error("strobe pin did not load latch");

	chk_pin_blanks: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(ce && force_off) ##1 ce ##1 ce |=> (sinks == '0))
		else $error("force-off pin did not blank sinks");

	chk_pin_unblanks: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(ce && !force_off) ##1 ce ##1 ce |=> (sinks == latch))
		else $error("sinks not latch after force-off low");
endmodule

/* File: rtl/lsd_pkg.sv */
// lsd_pkg: shared constants and carrier types for the led sink shift path
// assumes: included before the design modules, nothing imported
package lsd_pkg;
	// ------------------------------------------------------------
	// widths and field layout
	// ------------------------------------------------------------
	localparam int SHIFT_LEN  = 25;
	localparam int GROUP_LEN  = 8;
	localparam int RED_LSB    = 0;
	localparam int GREEN_LSB  = 8;
	localparam int BLUE_LSB   = 16;
	localparam int SYNC_DEPTH = 2;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [24:0] SHIFT_RST = 25'h0000000;
	localparam logic [23:0] LATCH_RST = 24'h000000;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] blue;
		logic [7:0] green;
		logic [7:0] red;
	} lsd_sinks_s;

	typedef struct packed {
		logic serial_in;
		logic shift_clk;
		logic load_strobe;
		logic force_off;
	} lsd_pins_s;
endpackage

/* File: rtl/lsd_sync.sv */
// lsd_sync: two-stage synchroniser for a group of pin levels
// assumes: inputs asynchronous to mclk; first stage read only by the second
module lsd_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             mclk,   // system clock
	input  wire logic             rst_n,  // async reset, active low
	input  wire logic             ce,     // clock enable
	input  wire logic [WIDTH-1:0] d,      // raw pin levels
	output logic      [WIDTH-1:0] q       // synchronised levels
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_q;

	always_comb begin
		next_meta = ce ? d : meta;
		next_q    = ce ? meta : q;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= next_meta;
			q    <= next_q;
		end
	end
endmodule

/* File: bench/lsd_ctl.sv */
// lsd_ctl: behavioural display controller driving the serial chain
// assumes: tasks called by the bench, mclk at 25 MHz
module lsd_ctl (
	input  wire logic mclk,        // system clock
	output logic      serial_in,   // data toward the block
	output logic      shift_clk,   // link clock, still between frames
	output logic      load_strobe  // latch strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		serial_in = 1'b0;
		shift_clk = 1'b0;
		load_strobe = 1'b0;
	end
	// ------------------------------------------------------------
	// frames
	// ------------------------------------------------------------
	// one bit per rise, msb first, 320 ns period
	task automatic send(input logic [24:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge mclk) serial_in <= w[i];
			repeat (2) @(posedge mclk);
			shift_clk <= 1'b1;
			repeat (4) @(posedge mclk);
			shift_clk <= 1'b0;
			repeat (1) @(posedge mclk);
		end
		// released data line must not keep its last level
		serial_in <= ~serial_in;
	endtask
	task automatic strobe();
		@(posedge mclk) load_strobe <= 1'b1;
		repeat (4) @(posedge mclk);
		load_strobe <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask
endmodule

/* File: bench/tb.sv */
// tb: top bench for lsd_core with a controller model on the pins
// assumes: lsd_pkg and design files compiled first
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [24:0] WORD = 25'h1A5C3E1;
	logic                mclk;
	logic                rst_n;
	logic                force_off;
	logic                serial_in;
	logic                shift_clk;
	logic                load_strobe;
	logic                serial_out;
	logic                ce;
	wire lsd_pkg::lsd_sinks_s sinks;
	int                  n_fail = 0;
	int                  n_checks = 0;
	int                  cycles = 0;
	lsd_ctl i_ctl (.mclk(mclk), .serial_in(serial_in),
		.shift_clk(shift_clk), .load_strobe(load_strobe));
	lsd_core i_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
		.serial_in(serial_in), .shift_clk(shift_clk),
		.load_strobe(load_strobe), .force_off(force_off),
		.serial_out(serial_out), .red_sinks(sinks.red),
		.green_sinks(sinks.green), .blue_sinks(sinks.blue));
	task automatic check(input logic [24:0] got, input logic [24:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_load();
		i_ctl.send(WORD, 25);
		check({24'h0, serial_out}, {24'h0, WORD[24]});
		check({1'b0, sinks}, 25'h0);
		i_ctl.strobe();
		check({1'b0, sinks}, {1'b0, WORD[23:0]});
	endtask
	task automatic t_shift_more();
		i_ctl.send(25'h0, 1);
		check({24'h0, serial_out}, {24'h0, WORD[23]});
		check({1'b0, sinks}, {1'b0, WORD[23:0]});
		i_ctl.strobe();
		check({1'b0, sinks}, {1'b0, WORD[22:0], 1'b0});
	endtask
	task automatic t_blank();
		@(posedge mclk) force_off <= 1'b1;
		repeat (4) @(posedge mclk);
		check({1'b0, sinks}, 25'h0);
		force_off <= 1'b0;
		repeat (4) @(posedge mclk);
		check({1'b0, sinks}, {1'b0, WORD[22:0], 1'b0});
	endtask
	// edges seen while ce is low must be lost, not replayed later
	task automatic t_freeze();
		@(posedge mclk) ce <= 1'b0;
		i_ctl.send(25'h1, 1);
		i_ctl.strobe();
		@(posedge mclk) ce <= 1'b1;
		repeat (4) @(posedge mclk);
		check({24'h0, serial_out}, {24'h0, WORD[23]});
		i_ctl.strobe();
		check({1'b0, sinks}, {1'b0, WORD[22:0], 1'b0});
	endtask
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// hang guard, the run needs about 280 cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			n_fail++;
			finish_test();
		end
	end
	initial begin
		rst_n = 1'b0;
		force_off = 1'b0;
		ce = 1'b1;
		repeat (12) @(posedge mclk);
		check({24'h0, serial_out}, 25'h0);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		t_load();
		t_shift_more();
		t_blank();
		t_freeze();
		finish_test();
	end
endmodule
